// File: hw/isr_pkg.sv
// package: constants and types of the init source reset distributor
package isr_pkg;
	// ************************************************************
	// register map (byte addresses on the avalon slave)
	// ************************************************************
	localparam int ISR_AW = 5;
	localparam logic [4:0] ISR_OFS_CTRL = 5'h00;
	localparam logic [4:0] ISR_OFS_STATUS = 5'h04;
	localparam logic [4:0] ISR_OFS_MASK = 5'h08;
	localparam logic [4:0] ISR_OFS_STATE = 5'h0c;
	// ctrl fields
	localparam int ISR_CTRL_SW_RST = 0;
	localparam int ISR_CTRL_SEL_RST = 1;
	localparam int ISR_CTRL_STAT_EN = 2;
	localparam int ISR_CTRL_RX_EN = 3;
	// event bits, same layout in status and mask
	localparam int ISR_NEV = 6;
	localparam int ISR_EV_ALT = 0;
	localparam int ISR_EV_HOST = 1;
	localparam int ISR_EV_ISO = 2;
	localparam int ISR_EV_D3D0 = 3;
	localparam int ISR_EV_SW = 4;
	localparam int ISR_EV_SEL = 5;
	localparam logic [5:0] ISR_MASK_RST = 6'h00;
	// power states
	localparam logic [1:0] ISR_PWR_D0 = 2'h0;
	localparam logic [1:0] ISR_PWR_D3 = 2'h3;
	// ************************************************************
	// reset scopes, msb first: eeprom ucode mac mem pci phy pme stats
	// ************************************************************
	localparam logic [7:0] ISR_SCOPE_ALT = 8'hff;
	localparam logic [7:0] ISR_SCOPE_HOST = 8'hfd;
	localparam logic [7:0] ISR_SCOPE_PME = 8'h02;
	localparam logic [7:0] ISR_SCOPE_ISO = 8'ha8;
	localparam logic [7:0] ISR_SCOPE_D3D0 = 8'h79;
	localparam logic [7:0] ISR_SCOPE_SW = 8'h71;
	localparam logic [7:0] ISR_SCOPE_SEL = 8'h10;

	typedef struct packed {
		logic eeprom_load;
		logic microcode;
		logic mac_cfg;
		logic mem_ptr;
		logic pci_cfg;
		logic phy_cfg;
		logic pme;
		logic stats;
	} isr_scope_s;

	typedef enum logic [2:0] {
		ISR_CAUSE_NONE = 3'h0,
		ISR_CAUSE_ALT = 3'h1,
		ISR_CAUSE_HOST = 3'h2,
		ISR_CAUSE_ISO = 3'h3,
		ISR_CAUSE_D3D0 = 3'h4,
		ISR_CAUSE_SW = 3'h5,
		ISR_CAUSE_SEL = 3'h6
	} isr_cause_e;

	typedef struct packed {
		logic rd_busy;
		logic wr_busy;
		logic status_read;
		logic [7:0] rd_data;
	} isr_mgmt_in_s;

	typedef struct packed {
		logic terminate;
		logic wr_discard;
		logic status_en;
		logic rx_en;
		logic init_bit;
		logic [7:0] rd_data;
	} isr_mgmt_out_s;
endpackage : isr_pkg

// File: hw/isr_sync.sv
// three-flop synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module isr_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} isr_sync_st_s;

	isr_sync_st_s st_reg;
	isr_sync_st_s st_next;
	logic [W-1:0] agree;

	// s1 only feeds s2; the filter looks at s2 and s3
	always_comb begin
		st_next = st_reg;
		agree = ~(st_reg.s2 ^ st_reg.s3);
		st_next.s1 = d;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
		st_next.q = (st_reg.q & ~agree) | (st_reg.s2 & agree);
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.q;
endmodule : isr_sync
`default_nettype wire

// File: hw/isr_flag.sv
// sticky flags, set wins over clear
`timescale 1ns/1ns
`default_nettype none
module isr_flag #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [W-1:0] set,
	input wire logic [W-1:0] clr,
	output logic [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] q;
	} isr_flag_st_s;

	isr_flag_st_s st_reg;
	isr_flag_st_s st_next;

	// an event in the clearing cycle is kept
	always_comb begin
		st_next = st_reg;
		st_next.q = (st_reg.q & ~clr) | set;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign q = st_reg.q;
endmodule : isr_flag
`default_nettype wire

// File: hw/isr_dist.sv
// init source reset distributor: top module
//
// Local design decisions: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ns
`default_nettype none
module isr_dist
	import isr_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [isr_pkg::ISR_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic irq,
	input wire logic alt_hw_reset_n,
	input wire logic host_bus_reset_n,
	input wire logic bus_n_a,
	input wire logic aux_power,
	input wire logic [1:0] power_state,
	input wire isr_pkg::isr_mgmt_in_s mgmt_in,
	output var isr_pkg::isr_mgmt_out_s mgmt_out,
	output logic mgmt_alert_n_o,
	output logic mgmt_alert_n_oe,
	output var isr_pkg::isr_scope_s rst_scope,
	output var isr_pkg::isr_cause_e reset_cause
);
	import isr_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic stat_en;
		logic rx_en;
		logic [5:0] mask;
		logic [1:0] pwr_prev;
		logic alt_low_prev;
		logic host_low_prev;
		logic iso_low_prev;
		logic host_d3;
		logic abort_rd;
		logic abort_wr;
		logic terminate;
		logic [7:0] scope;
		isr_cause_e cause;
		logic [7:0] mgmt_rd_data;
	} isr_dist_st_s;

	isr_dist_st_s st_reg;
	isr_dist_st_s st_next;

	logic [3:0] pins_s;
	logic alt_low;
	logic host_low;
	logic iso_low;
	logic aux_s;
	logic alt_fall;
	logic host_fall;
	logic host_rise;
	logic iso_rise;
	logic host_lvl;
	logic host_tp;
	logic d3d0;
	logic bus_req;
	logic accept;
	logic wr_ctrl;
	logic sw_ev;
	logic sel_ev;
	logic hard_rst;
	logic [5:0] ev;
	logic [5:0] ev_clr;
	logic [5:0] ev_stat;
	logic [1:0] am_set;
	logic [1:0] am_clr;
	logic [1:0] am_q;

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	// async pins pass three flops
	isr_sync #(
		.W(4),
		.RST_VAL(4'h7)
	) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.d({aux_power, bus_n_a, host_bus_reset_n, alt_hw_reset_n}),
		.q(pins_s)
	);

	assign alt_low = ~pins_s[0];
	assign host_low = ~pins_s[1];
	assign iso_low = ~pins_s[2];
	assign aux_s = pins_s[3];

	// ************************************************************
	// source events
	// ************************************************************
	assign alt_fall = alt_low & ~st_reg.alt_low_prev;
	assign host_fall = host_low & ~st_reg.host_low_prev;
	assign host_rise = ~host_low & st_reg.host_low_prev;
	assign iso_rise = ~iso_low & st_reg.iso_low_prev;
	// host reset entered in d3 acts on release
	assign host_lvl = host_low & ~st_reg.host_d3 & ~(host_fall & (power_state == ISR_PWR_D3));
	assign host_tp = host_rise & st_reg.host_d3;
	assign d3d0 = (st_reg.pwr_prev == ISR_PWR_D3) & (power_state == ISR_PWR_D0);
	assign hard_rst = alt_low | host_lvl | host_tp | iso_rise;

	assign bus_req = avs_read | avs_write;
	assign accept = bus_req & st_reg.ack;
	assign wr_ctrl = accept & avs_write & (avs_address == ISR_OFS_CTRL);
	assign sw_ev = wr_ctrl & avs_writedata[ISR_CTRL_SW_RST];
	assign sel_ev = wr_ctrl & avs_writedata[ISR_CTRL_SEL_RST];

	always_comb begin
		ev = '0;
		ev[ISR_EV_ALT] = alt_fall;
		ev[ISR_EV_HOST] = (host_fall & host_lvl) | host_tp;
		ev[ISR_EV_ISO] = iso_rise;
		ev[ISR_EV_D3D0] = d3d0;
		ev[ISR_EV_SW] = sw_ev;
		ev[ISR_EV_SEL] = sel_ev;
		ev_clr = '0;
		if (accept && avs_write && (avs_address == ISR_OFS_STATUS)) begin
			ev_clr = avs_writedata[5:0];
		end
	end

	// ************************************************************
	// interrupt status, write one to clear
	// ************************************************************
	isr_flag #(
		.W(ISR_NEV)
	) u_stat (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.set(ev),
		.clr(ev_clr),
		.q(ev_stat)
	);

	// ************************************************************
	// alert and init bit toward the management controller
	// ************************************************************
	// alert and init bit set by d3d0
	assign am_set = {d3d0, d3d0};
	// both cleared only by a status word read
	assign am_clr = {mgmt_in.status_read, mgmt_in.status_read};

	isr_flag #(
		.W(2)
	) u_alert (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.set(am_set),
		.clr(am_clr),
		.q(am_q)
	);

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		st_next = st_reg;
		st_next.pwr_prev = power_state;
		st_next.alt_low_prev = alt_low;
		st_next.host_low_prev = host_low;
		st_next.iso_low_prev = iso_low;
		if (host_fall && (power_state == ISR_PWR_D3)) begin
			st_next.host_d3 = 1'h1;
		end else if (!host_low) begin
			st_next.host_d3 = 1'h0;
		end

		st_next.scope = 8'h00;
		if (alt_low) begin
			st_next.scope = st_next.scope | ISR_SCOPE_ALT;
		end
		// host clears pme only without aux power
		if (host_lvl || host_tp) begin
			st_next.scope = st_next.scope | ISR_SCOPE_HOST;
			if (!aux_s) begin
				st_next.scope = st_next.scope | ISR_SCOPE_PME;
			end
		end
		if (iso_rise) begin
			st_next.scope = st_next.scope | ISR_SCOPE_ISO;
		end
		if (d3d0) begin
			st_next.scope = st_next.scope | ISR_SCOPE_D3D0;
		end
		if (sw_ev) begin
			st_next.scope = st_next.scope | ISR_SCOPE_SW;
		end
		if (sel_ev) begin
			st_next.scope = st_next.scope | ISR_SCOPE_SEL;
		end

		// highest ranked active source is reported
		if (alt_low) begin
			st_next.cause = ISR_CAUSE_ALT;
		end else if (host_lvl || host_tp) begin
			st_next.cause = ISR_CAUSE_HOST;
		end else if (iso_rise) begin
			st_next.cause = ISR_CAUSE_ISO;
		end else if (d3d0) begin
			st_next.cause = ISR_CAUSE_D3D0;
		end else if (sw_ev) begin
			st_next.cause = ISR_CAUSE_SW;
		end else if (sel_ev) begin
			st_next.cause = ISR_CAUSE_SEL;
		end

		// host side never waits on the mgmt transaction
		// hard resets cut the mgmt bus at once
		st_next.terminate = hard_rst;
		// read aborted until its cycle ends
		st_next.abort_rd = mgmt_in.rd_busy & (d3d0 | st_reg.abort_rd);
		st_next.abort_wr = mgmt_in.wr_busy & (d3d0 | hard_rst | st_reg.abort_wr);
		st_next.mgmt_rd_data = st_next.abort_rd ? 8'h00 : mgmt_in.rd_data;

		// ************************************************************
		// avalon slave: one wait cycle then answer
		// ************************************************************
		st_next.ack = bus_req & ~st_reg.ack;
		if (avs_read && !st_reg.ack) begin
			case (avs_address)
				ISR_OFS_CTRL: begin
					st_next.rdata = {28'h0000000, st_reg.rx_en, st_reg.stat_en, 2'h0};
				end
				ISR_OFS_STATUS: begin
					st_next.rdata = {26'h0000000, ev_stat};
				end
				ISR_OFS_MASK: begin
					st_next.rdata = {26'h0000000, st_reg.mask};
				end
				ISR_OFS_STATE: begin
					st_next.rdata = {23'h000000, aux_s, power_state, st_reg.cause,
						st_reg.abort_rd | st_reg.abort_wr, am_q};
				end
				default: begin
					st_next.rdata = 32'h00000000;
				end
			endcase
		end
		if (wr_ctrl) begin
			st_next.stat_en = avs_writedata[ISR_CTRL_STAT_EN];
			st_next.rx_en = avs_writedata[ISR_CTRL_RX_EN];
		end
		if (accept && avs_write && (avs_address == ISR_OFS_MASK)) begin
			st_next.mask = avs_writedata[5:0];
		end
		// status and receive enable forced inactive
		if (hard_rst || d3d0) begin
			st_next.stat_en = 1'h0;
			st_next.rx_en = 1'h0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '{
				ack: 1'h0,
				rdata: 32'h00000000,
				stat_en: 1'h0,
				rx_en: 1'h0,
				mask: ISR_MASK_RST,
				pwr_prev: ISR_PWR_D0,
				alt_low_prev: 1'h0,
				host_low_prev: 1'h0,
				iso_low_prev: 1'h0,
				host_d3: 1'h0,
				abort_rd: 1'h0,
				abort_wr: 1'h0,
				terminate: 1'h0,
				scope: 8'h00,
				cause: ISR_CAUSE_NONE,
				mgmt_rd_data: 8'h00
			};
		end else begin
			st_reg <= st_next;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign avs_waitrequest = bus_req & ~st_reg.ack;
	assign avs_readdata = st_reg.rdata;
	assign irq = |(ev_stat & st_reg.mask);
	assign rst_scope = isr_scope_s'(st_reg.scope);
	assign reset_cause = st_reg.cause;
	// one driver for the whole struct
	assign mgmt_out = '{st_reg.terminate, st_reg.abort_wr, st_reg.stat_en, st_reg.rx_en,
		am_q[1], st_reg.mgmt_rd_data};
	// open drain: only ever pulls low
	assign mgmt_alert_n_o = 1'h0;
	assign mgmt_alert_n_oe = am_q[0];

	// ************************************************************
	// checks
	// ************************************************************
	a_sel_scope_only: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(sel_ev && !sw_ev && !hard_rst && !d3d0) |=> (rst_scope == ISR_SCOPE_SEL))
		else $error("selective reset scope wrong");
	a_sw_within_d3d0: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		sw_ev |=> ((rst_scope & ISR_SCOPE_SW) == ISR_SCOPE_SW) && !rst_scope.pci_cfg
			|| $past(hard_rst || d3d0))
		else $error("software reset scope wrong");
	a_eeprom_source: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		rst_scope.eeprom_load |-> $past(hard_rst))
		else $error("eeprom load without hard reset");
	a_pme_aux_kept: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(host_lvl && aux_s && !alt_low) |=> !rst_scope.pme)
		else $error("pme cleared with aux power");
	a_iso_trailing: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(iso_low && !alt_low && !host_lvl && !host_tp && !d3d0) |=> !rst_scope.pci_cfg)
		else $error("bus_n_a acted before release");
	a_term_mgmt: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		hard_rst |=> mgmt_out.terminate && !mgmt_out.status_en && !mgmt_out.rx_en)
		else $error("mgmt not terminated");
	a_abort_zero: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(d3d0 && mgmt_in.rd_busy) ##1 mgmt_in.rd_busy |-> (mgmt_out.rd_data == 8'h00))
		else $error("aborted read returned data");
	a_write_discard: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(d3d0 && mgmt_in.wr_busy) |=> mgmt_out.wr_discard)
		else $error("write not discarded");
	a_alert_init: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		d3d0 |=> mgmt_alert_n_oe && mgmt_out.init_bit)
		else $error("no alert after d3d0");
	a_alert_hold: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		(mgmt_alert_n_oe && !mgmt_in.status_read) |=> mgmt_alert_n_oe)
		else $error("alert dropped before status read");
	a_bus_one_wait: assert property (
		@(posedge core_clk) disable iff (!arst_n)
		avs_waitrequest |=> !avs_waitrequest)
		else $error("waitrequest held too long");
endmodule : isr_dist
`default_nettype wire

// File: dv/isr_mgmt_model.sv
// management controller model facing the mgmt port of the distributor
`timescale 1ns/1ns
`default_nettype none
module isr_mgmt_model (
	input wire logic core_clk,
	output var isr_pkg::isr_mgmt_in_s mgmt_in
);
	import isr_pkg::*;
	// ************************************************************
	// read path and cycles
	// ************************************************************
	logic [7:0] pat = 8'h5a;
	initial mgmt_in = '0;
	// idle byte flips each cycle so a stale value never passes
	always @(posedge core_clk) begin
		pat <= pat + 8'h01;
		mgmt_in.rd_data <= mgmt_in.rd_busy ? pat : ~mgmt_in.rd_data;
	end
	task automatic cycle(input bit is_wr, input int n);
		@(posedge core_clk);
		if (is_wr) mgmt_in.wr_busy <= 1'b1;
		else mgmt_in.rd_busy <= 1'b1;
		repeat (n) @(posedge core_clk);
		mgmt_in.wr_busy <= 1'b0;
		mgmt_in.rd_busy <= 1'b0;
	endtask : cycle
	task automatic read_status();
		@(posedge core_clk);
		mgmt_in.status_read <= 1'b1;
		@(posedge core_clk);
		mgmt_in.status_read <= 1'b0;
	endtask : read_status
endmodule : isr_mgmt_model
`default_nettype wire

// File: dv/isr_tb.sv
// self-checking bench of the init source reset distributor
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("Error %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	import isr_pkg::*;
	// ************************************************************
	// signals and instances
	// ************************************************************
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic irq;
	logic alt_n = 1'b1;
	logic host_n = 1'b1;
	logic bus_n_a = 1'b1;
	logic aux_power = 1'b1;
	logic [1:0] power_state = ISR_PWR_D0;
	isr_mgmt_in_s mgmt_in;
	isr_mgmt_out_s mgmt_out;
	logic alert_n_o;
	logic alert_oe;
	isr_scope_s rst_scope;
	isr_cause_e reset_cause;
	logic [7:0] acc = 8'h00;
	logic term = 1'b0;
	logic acc_clr = 1'b0;
	int errors = 0;
	int tests_run = 0;
	int cyc = 0;
	always #25 core_clk = ~core_clk;
	isr_dist dut (.core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
		.alt_hw_reset_n(alt_n), .host_bus_reset_n(host_n), .bus_n_a(bus_n_a),
		.aux_power(aux_power), .power_state(power_state), .mgmt_in(mgmt_in),
		.mgmt_out(mgmt_out), .mgmt_alert_n_o(alert_n_o), .mgmt_alert_n_oe(alert_oe),
		.rst_scope(rst_scope), .reset_cause(reset_cause));
	isr_mgmt_model mdl (.core_clk(core_clk), .mgmt_in(mgmt_in));
	// scopes and terminations seen since the last clear
	always @(posedge core_clk) begin
		acc <= acc_clr ? 8'h00 : acc | rst_scope;
		term <= acc_clr ? 1'b0 : term | mgmt_out.terminate;
		cyc++;
		if (cyc == 6000) begin
			errors++;
			close_out();
		end
	end
	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask : tick
	task automatic clr();
		@(posedge core_clk);
		acc_clr <= 1'b1;
		@(posedge core_clk);
		acc_clr <= 1'b0;
	endtask : clr
	task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
			output logic [31:0] q);
		@(posedge core_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= ~w;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask : rd
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_sw_sel();
		logic [31:0] q;
		clr();
		wr(ISR_OFS_CTRL, 32'h0d);
		tick(3);
		`CHK("sw scope", ISR_SCOPE_SW, acc)
		`CHK("sw cause", ISR_CAUSE_SW, reset_cause)
		`CHK("sw status_en", 1'b1, mgmt_out.status_en)
		rd(ISR_OFS_CTRL, q);
		`CHK("ctrl enables", 32'h0c, q)
		clr();
		wr(ISR_OFS_CTRL, 32'h0e);
		tick(3);
		`CHK("sel scope", ISR_SCOPE_SEL, acc)
		`CHK("sel cause", ISR_CAUSE_SEL, reset_cause)
		`CHK("sel term", 1'b0, term)
		rd(ISR_OFS_STATUS, q);
		`CHK("status sw sel", 32'h30, q)
		wr(ISR_OFS_STATUS, 32'h30);
		rd(ISR_OFS_STATUS, q);
		`CHK("status cleared", 32'h0, q)
		$display("test sw_sel done");
	endtask : t_sw_sel
	task automatic t_alt();
		logic [31:0] q;
		rd(ISR_OFS_MASK, q);
		`CHK("mask reset", 32'h0, q)
		wr(5'h10, 32'hffffffff);
		rd(5'h10, q);
		`CHK("unmapped", 32'h0, q)
		rd(ISR_OFS_MASK, q);
		`CHK("mask kept", 32'h0, q)
		wr(ISR_OFS_MASK, 32'h1);
		wr(ISR_OFS_CTRL, 32'h0c);
		clr();
		`CHK("irq idle", 1'b0, irq)
		alt_n <= 1'b0;
		tick(10);
		`CHK("alt scope", ISR_SCOPE_ALT, acc)
		`CHK("alt term", 1'b1, term)
		`CHK("alt status_en", 1'b0, mgmt_out.status_en)
		`CHK("alt rx_en", 1'b0, mgmt_out.rx_en)
		`CHK("alt cause", ISR_CAUSE_ALT, reset_cause)
		alt_n <= 1'b1;
		tick(8);
		`CHK("irq set", 1'b1, irq)
		wr(ISR_OFS_STATUS, 32'h1);
		tick(2);
		`CHK("irq clear", 1'b0, irq)
		$display("test alt done");
	endtask : t_alt
	task automatic t_host();
		aux_power <= 1'b0;
		tick(6);
		clr();
		host_n <= 1'b0;
		tick(8);
		wr(ISR_OFS_CTRL, 32'h01);
		tick(4);
		`CHK("host noaux scope", ISR_SCOPE_HOST | ISR_SCOPE_PME, acc)
		`CHK("host rank", ISR_CAUSE_HOST, reset_cause)
		host_n <= 1'b1;
		aux_power <= 1'b1;
		tick(8);
		clr();
		host_n <= 1'b0;
		tick(10);
		host_n <= 1'b1;
		tick(8);
		`CHK("host aux scope", ISR_SCOPE_HOST, acc)
		power_state <= ISR_PWR_D3;
		tick(2);
		clr();
		host_n <= 1'b0;
		tick(10);
		`CHK("host d3 held", 8'h00, acc)
		`CHK("host d3 no term", 1'b0, term)
		host_n <= 1'b1;
		tick(10);
		`CHK("host d3 release", ISR_SCOPE_HOST, acc)
		`CHK("host d3 term", 1'b1, term)
		$display("test host done");
	endtask : t_host
	task automatic t_iso();
		clr();
		fork
			mdl.cycle(1'b1, 30);
			begin
				bus_n_a <= 1'b0;
				tick(10);
				`CHK("iso held", 8'h00, acc)
				bus_n_a <= 1'b1;
				tick(10);
				`CHK("iso scope", ISR_SCOPE_ISO, acc)
				`CHK("iso term", 1'b1, term)
				`CHK("iso cause", ISR_CAUSE_ISO, reset_cause)
				`CHK("iso wr discard", 1'b1, mgmt_out.wr_discard)
			end
		join
		tick(3);
		`CHK("iso wr discard end", 1'b0, mgmt_out.wr_discard)
		$display("test iso done");
	endtask : t_iso
	task automatic t_d3d0();
		logic [31:0] q;
		wr(ISR_OFS_CTRL, 32'h0c);
		clr();
		fork
			mdl.cycle(1'b0, 20);
			begin
				tick(6);
				power_state <= ISR_PWR_D0;
				tick(3);
				`CHK("abort rd", 8'h00, mgmt_out.rd_data)
				tick(8);
				`CHK("abort rd late", 8'h00, mgmt_out.rd_data)
			end
		join
		`CHK("d3d0 scope", ISR_SCOPE_D3D0, acc)
		`CHK("d3d0 term", 1'b0, term)
		`CHK("d3d0 status_en", 1'b0, mgmt_out.status_en)
		`CHK("alert oe", 1'b1, alert_oe)
		`CHK("alert level", 1'b0, alert_n_o)
		`CHK("init bit", 1'b1, mgmt_out.init_bit)
		rd(ISR_OFS_STATE, q);
		`CHK("state word", {23'h000000, 1'b1, ISR_PWR_D0, ISR_CAUSE_D3D0, 3'h3}, q)
		mdl.read_status();
		tick(3);
		`CHK("alert released", 1'b0, alert_oe)
		`CHK("init cleared", 1'b0, mgmt_out.init_bit)
		power_state <= ISR_PWR_D3;
		tick(3);
		fork
			mdl.cycle(1'b1, 12);
			begin
				tick(4);
				power_state <= ISR_PWR_D0;
				tick(3);
				`CHK("wr discard", 1'b1, mgmt_out.wr_discard)
			end
		join
		tick(3);
		`CHK("wr discard end", 1'b0, mgmt_out.wr_discard)
		$display("test d3d0 done");
	endtask : t_d3d0
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out
	initial begin
		tick(10);
		arst_n <= 1'b1;
		tick(6);
		t_sw_sel();
		t_alt();
		t_host();
		t_iso();
		t_d3d0();
		close_out();
	end
endmodule : testbench
`default_nettype wire
